//--- rtl/gsw_defines.vh
`ifndef GSW_DEFINES_VH
`define GSW_DEFINES_VH
// acyclic parameter indexes
`define GSW_IDX_COMMAND_TRIGGER 16'h0002
`define GSW_IDX_ERROR_TALLY     16'h0020
`define GSW_IDX_HEALTH_SUMMARY  16'h0024
// cyclic input word field positions
`define GSW_POS_MSB        31
`define GSW_POS_LSB        16
`define GSW_SWITCH_MSB     15
`define GSW_SWITCH_LSB     12
`define GSW_BIT_LOST_PART  11
`define GSW_BIT_SERVICE    7
`define GSW_BIT_THERM_WARN 6
`define GSW_BIT_THERM_FLT  5
`define GSW_BIT_FAULT      4
`define GSW_BIT_HOLDING    3
`define GSW_BIT_NO_PART    2
`define GSW_BIT_RELEASED   1
`define GSW_BIT_INACTIVE   0
// temperature thresholds in 1/10 degree C
`define GSW_TEMP_WARN_LO   16'sd0
`define GSW_TEMP_WARN_HI   16'sd600
`define GSW_TEMP_HYST      16'sd20
`define GSW_TEMP_FLT_SET   16'sd700
`define GSW_TEMP_FLT_CLR   16'sd680
// system command codes (arbitrary local encodings)
`define GSW_CMD_SERVICE_ACK 8'ha0
`define GSW_CMD_STORE       8'ha1
// gripping state codes
`define GSW_ST_IDLE     3'h0
`define GSW_ST_RELEASED 3'h1
`define GSW_ST_NO_PART  3'h2
`define GSW_ST_HOLDING  3'h3
`define GSW_ST_ERROR    3'h4
`endif

//--- rtl/gsw_status_word.v
`timescale 1ns/1ps
`include "gsw_defines.vh"
// Notes on behaviour
// (R1) a fresh four-byte input word is presented every cycle
// (R2) the word is shifted out most significant byte first
// (R3) jaw position, signed, 1/100 mm, in bits 31..16
// (R4) each switch flag set while position lies in its range
// (R5) lost-part flag set on holding to no-part transition
// (R6) lost-part flag cleared on a release command
// (R7) master ignores reserved bits 10..9; they read zero
// (R8) service-due flag set when the service interval is reached
// (R9) service acknowledge command clears the flag and the service counter
// (R10) thermal warning set below 0 C or above 60 C
// (R11) thermal warning clears only 2 C inside the allowed range
// (R12) thermal fault set above 70 C
// (R13) thermal fault clears only below 68 C
// (R14) fault flag follows the error state
// (R15) holding flag shows a part gripped inside the limits
// (R16) no-part flag shows jaws at or past the no-part limit
// (R17) released flag shows jaws at or past the release limit
// (R18) inactive flag set while drive is force-free; grip commands refused
// (R19) parameters selected by 16-bit index plus 8-bit subindex; the subindex input is ignored here
// (R20) write-only system command at index 0x02 executes its code
// (R21) index 0x20 reads a 16-bit error count since start
// (R22) store command copies parameters to non-volatile storage
// (R23) master with data storage downloads parameters at activation
// (R24) holding, no-part and released flags are mutually exclusive
module gsw_status_word #(
	parameter SERVICE_INTERVAL = 32'd1000000
) (
	input  wire        clk_i,
	input  wire        reset_i,
	input  wire [15:0] jaw_position_i,
	input  wire [63:0] switch_center_i,
	input  wire [63:0] switch_width_i,
	input  wire [2:0]  grip_state_i,
	input  wire        drive_enable_i,
	input  wire        grip_command_i,
	input  wire        release_command_i,
	input  wire        grip_cycle_done_i,
	input  wire [15:0] temperature_i,
	input  wire        param_write_i,
	input  wire        param_read_i,
	input  wire [15:0] param_index_i,
	input  wire [7:0]  param_subindex_i,
	input  wire [15:0] param_wdata_i,
	input  wire        frame_start_i,
	output reg  [31:0] cyclic_input_word_o,
	output reg  [7:0]  link_byte_o,
	output reg         link_byte_valid_o,
	output reg  [15:0] param_rdata_o,
	output reg         param_ack_o,
	output reg         param_error_o,
	output wire        grip_allowed_o,
	output reg         store_request_o
);

	// ******************************
	// switch window decode
	// ******************************
	function in_window;
		input signed [15:0] pos;
		input signed [15:0] center;
		input [15:0]        width;
		reg signed [17:0]   half;
		reg signed [17:0]   d;
		begin
			half = {3'h0, width[15:1]};
			d = {{2{pos[15]}}, pos} - {{2{center[15]}}, center};
			in_window = (d >= -half) && (d <= half);
		end
	endfunction

	wire [3:0] switch_hit;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_sw
			assign switch_hit[g] = in_window(jaw_position_i, switch_center_i[g*16 +: 16],
				switch_width_i[g*16 +: 16]); // R4
		end
	endgenerate

	// ******************************
	// state and command decode
	// ******************************
	// gripping state compare, shared by the event edges and the word bits
	function state_is;
		input [2:0] state;
		input [2:0] code;
		begin
			state_is = (state == code);
		end
	endfunction

	// a command needs the trigger index and one exact code; other codes are no-ops
	function command_is;
		input        write;
		input [15:0] index;
		input [7:0]  data;
		input [7:0]  code;
		begin
			command_is = write && (index == `GSW_IDX_COMMAND_TRIGGER) && (data == code);
		end
	endfunction

	// ******************************
	// flags
	// ******************************
	// flag and counter state
	reg        lost_part_flag;
	reg        service_due_flag;
	reg        thermal_warning_flag;
	reg        thermal_fault_flag;
	reg [31:0] service_count;
	reg [15:0] error_tally;
	reg [2:0]  prev_state;
	reg        prev_error;

	wire signed [15:0] temp = temperature_i;
	wire cmd_write  = param_write_i && (param_index_i == `GSW_IDX_COMMAND_TRIGGER); // R19 R20
	wire svc_ack    = command_is(param_write_i, param_index_i, param_wdata_i[7:0], `GSW_CMD_SERVICE_ACK);
	wire store_cmd  = command_is(param_write_i, param_index_i, param_wdata_i[7:0], `GSW_CMD_STORE);
	wire lost_event = state_is(prev_state, `GSW_ST_HOLDING) && state_is(grip_state_i, `GSW_ST_NO_PART);
	wire is_error   = state_is(grip_state_i, `GSW_ST_ERROR);

	// grip commands are blocked while the drive is force-free
	assign grip_allowed_o = drive_enable_i && !is_error; // R18

	// part loss is sticky; the loss event wins over a release in the same cycle
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			lost_part_flag <= 1'b0;
		end else if (lost_event) begin
			lost_part_flag <= 1'b1; // R5
		end else if (release_command_i) begin
			lost_part_flag <= 1'b0; // R6
		end
	end

	// state history for the loss and error-entry edges; idle after reset, so no false edge
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			prev_state <= `GSW_ST_IDLE;
			prev_error <= 1'b0;
		end else begin
			prev_state <= grip_state_i;
			prev_error <= is_error;
		end
	end

	// ******************************
	// service and error counters
	// ******************************
	// service counter saturates so an ignored flag never wraps back to clear
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			service_count <= 32'h0;
		end else if (svc_ack) begin
			service_count <= 32'h0; // R9
		end else if (grip_cycle_done_i && service_count != 32'hffffffff) begin
			service_count <= service_count + 32'h1;
		end
	end

	// the due condition is a level on the counter, so an acknowledge that also
	// zeroes the counter must win here, or the acknowledge would be lost
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			service_due_flag <= 1'b0;
		end else if (svc_ack) begin
			service_due_flag <= 1'b0; // R9
		end else if (service_count >= SERVICE_INTERVAL) begin
			service_due_flag <= 1'b1; // R8
		end
	end

	// errors counted on entry to the error state; saturates instead of wrapping
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			error_tally <= 16'h0;
		end else if (is_error && !prev_error && error_tally != 16'hffff) begin
			error_tally <= error_tally + 16'h1; // R21
		end
	end

	// ******************************
	// thermal flags
	// ******************************
	// warning band edges pulled in by the hysteresis margin; tenths of a degree
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			thermal_warning_flag <= 1'b0;
		end else if (temp < `GSW_TEMP_WARN_LO || temp > `GSW_TEMP_WARN_HI) begin
			thermal_warning_flag <= 1'b1; // R10
		end else if (temp >= `GSW_TEMP_WARN_LO + `GSW_TEMP_HYST &&
			temp <= `GSW_TEMP_WARN_HI - `GSW_TEMP_HYST) begin
			thermal_warning_flag <= 1'b0; // R11
		end
	end

	// fault set and clear points two degrees apart keep it from chattering
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			thermal_fault_flag <= 1'b0;
		end else if (temp > `GSW_TEMP_FLT_SET) begin
			thermal_fault_flag <= 1'b1; // R12
		end else if (temp < `GSW_TEMP_FLT_CLR) begin
			thermal_fault_flag <= 1'b0; // R13
		end
	end

	// ******************************
	// cyclic word assembly
	// ******************************
	// reserved bits stay zero through the default assignment
	reg [31:0] next_word;
	always @* begin
		next_word = 32'h0; // R7
		next_word[`GSW_POS_MSB:`GSW_POS_LSB] = jaw_position_i; // R3
		next_word[`GSW_SWITCH_MSB:`GSW_SWITCH_LSB] = switch_hit; // R4
		next_word[`GSW_BIT_LOST_PART] = lost_part_flag;
		next_word[`GSW_BIT_SERVICE] = service_due_flag;
		next_word[`GSW_BIT_THERM_WARN] = thermal_warning_flag;
		next_word[`GSW_BIT_THERM_FLT] = thermal_fault_flag;
		next_word[`GSW_BIT_FAULT] = is_error; // R14
		// one-hot decode of the state keeps these exclusive
		next_word[`GSW_BIT_HOLDING] = state_is(grip_state_i, `GSW_ST_HOLDING); // R15 R24
		next_word[`GSW_BIT_NO_PART] = state_is(grip_state_i, `GSW_ST_NO_PART); // R16 R24
		next_word[`GSW_BIT_RELEASED] = state_is(grip_state_i, `GSW_ST_RELEASED); // R17 R24
		next_word[`GSW_BIT_INACTIVE] = !drive_enable_i; // R18
	end

	// whole word registered every clock for the cyclic exchange
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cyclic_input_word_o <= 32'h0;
		end else begin
			cyclic_input_word_o <= next_word; // R1
		end
	end

	// serialiser latches a private copy at frame start, so a refresh in mid-frame
	// cannot tear the bytes already promised to the master
	reg [31:0] shift_word;
	reg [2:0]  byte_left;
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			shift_word <= 32'h0;
			byte_left <= 3'h0;
			link_byte_o <= 8'h0;
			link_byte_valid_o <= 1'b0;
		end else begin
			// a new start restarts the frame from the top byte
			if (frame_start_i) begin
				link_byte_o <= next_word[31:24]; // R2
				shift_word <= {next_word[23:0], 8'h0};
				byte_left <= 3'h3;
				link_byte_valid_o <= 1'b1;
			end else if (byte_left != 3'h0) begin
				link_byte_o <= shift_word[31:24]; // R2
				shift_word <= {shift_word[23:0], 8'h0};
				byte_left <= byte_left - 3'h1;
				link_byte_valid_o <= 1'b1;
			end else begin
				link_byte_valid_o <= 1'b0;
			end
		end
	end

	// ******************************
	// acyclic parameter access
	// ******************************
	// health ranks the worst active condition; warning and service share a level
	wire [7:0] health = is_error ? 8'h4 : (thermal_fault_flag ? 8'h3 :
		((thermal_warning_flag || service_due_flag) ? 8'h2 : 8'h0));

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			param_rdata_o <= 16'h0;
			param_ack_o <= 1'b0;
			param_error_o <= 1'b0;
			store_request_o <= 1'b0;
		end else begin
			// every access is acknowledged, refused or not, so the master never waits
			param_ack_o <= param_write_i || param_read_i;
			param_error_o <= 1'b0;
			store_request_o <= store_cmd; // R22
			if (param_write_i && !cmd_write)
				param_error_o <= 1'b1;
			if (param_read_i) begin
				case (param_index_i)
					`GSW_IDX_ERROR_TALLY: param_rdata_o <= error_tally; // R21
					`GSW_IDX_HEALTH_SUMMARY: param_rdata_o <= {8'h0, health};
					default: begin
						// command index is write-only; reads are refused
						param_rdata_o <= 16'h0;
						param_error_o <= 1'b1;
					end
				endcase
			end
		end
	end

endmodule // gsw_status_word

//--- bench/gsw_status_word_properties.sv
`timescale 1ns/1ps
// **
// status word checks
// **
module gsw_props #(parameter SERVICE_INTERVAL = 32'd4) (
	input wire        clk_i,
	input wire        reset_i,
	input wire [15:0] jaw_position_i,
	input wire [2:0]  grip_state_i,
	input wire        drive_enable_i,
	input wire [15:0] temperature_i,
	input wire        frame_start_i,
	input wire [31:0] cyclic_input_word_o,
	input wire        link_byte_valid_o,
	input wire        grip_allowed_o
);
	// one domain; $past guards skip the edge right after reset
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire signed [15:0] t = temperature_i;
	wire [31:0]        w = cyclic_input_word_o;
	chk_pos_field: assert property (!$past(reset_i) |-> w[31:16] == $past(jaw_position_i)) else $error("pos");
	chk_warn_hold: assert property ((t < 20 || t > 580) ##1 w[6] |=> w[6]) else $error("warn early");
	chk_fault_set: assert property (t > 700 |-> ##2 w[5]) else $error("fault");
	chk_fault_hold: assert property (t >= 680 ##1 w[5] |=> w[5]) else $error("fault early");
	chk_error_bit: assert property (!$past(reset_i) |-> w[4] == ($past(grip_state_i) == 3'h4)) else $error("err");
	chk_grip_flags: assert property ($onehot0(w[3:1])) else $error("flags");
	chk_frame_len: assert property (frame_start_i |=> link_byte_valid_o [*4] ##1 !link_byte_valid_o) else $error("len");
	chk_drive_gate: assert property (grip_allowed_o == (drive_enable_i && grip_state_i != 3'h4)) else $error("gate");
	// main scenarios reached
	cov_frame: cover property (frame_start_i);
	cov_fault: cover property (w[5]);
	cov_warn: cover property (w[6]);
endmodule // gsw_props
bind gsw_status_word gsw_props #(.SERVICE_INTERVAL(SERVICE_INTERVAL)) gsw_props_inst (.*);

//--- bench/gsw_master_model.sv
`timescale 1ns/1ps
// **
// link master model
// **
module gsw_master_model (
	input  wire        clk_i,
	input  wire        go_i,
	input  wire [7:0]  link_byte_i,
	input  wire        link_valid_i,
	output reg         frame_start_o,
	output wire [31:0] rx_word_o,
	output wire [63:0] switch_center_o,
	output wire [63:0] switch_width_o
);
	reg [31:0] shift = 32'h0;
	initial frame_start_o = 1'b0;
	// frame request and byte assembly; first byte ends up on top
	always @(posedge clk_i) begin
		frame_start_o <= go_i;
		if (link_valid_i)
			shift <= {shift[23:0], link_byte_i};
	end
	// reserved bits carry nothing the master may use
	assign rx_word_o = {shift[31:11], 2'b00, shift[8:0]};
	// saved switch set, handed down to the device from activation on
	assign switch_center_o = {16'hfe3f, 16'hfe3e, 16'h0, 16'hfe0c};
	assign switch_width_o = {16'h64, 16'h64, 16'hc8, 16'h64};
endmodule // gsw_master_model

//--- bench/test_gsw_status_word.sv
`timescale 1ns/1ps
`include "gsw_defines.vh"
// **
// status word bench
// **
module test_gsw_status_word;
	reg         clk = 1'b0, reset = 1'b1, en = 1'b1, rel = 1'b0, done = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
	reg  [15:0] jaw = 16'h0, temp = 16'hfa, idx = 16'h0, wd = 16'h0;
	reg  [2:0]  st = 3'h0;
	reg [161:0] tv = {16'd601, 2'b10, 16'd590, 2'b10, 16'd580, 2'b00, 16'd701, 2'b11, 16'd690, 2'b11,
		16'd679, 2'b10, 16'hffff, 2'b10, 16'd19, 2'b10, 16'd20, 2'b00};
	wire [31:0] word, rx;
	wire [63:0] centers, widths;
	wire [15:0] rdata;
	wire [7:0]  lb;
	wire        ack, err, allow, store, lv, fs;
	integer     n_errors = 0, cmp_count = 0, cyc = 0, stores = 0, snap, i;
	// 200 MHz
	always #2.5 clk = ~clk;
	gsw_status_word #(.SERVICE_INTERVAL(4)) gsw_status_word_inst (.clk_i(clk), .reset_i(reset), .jaw_position_i(jaw),
		.switch_center_i(centers), .switch_width_i(widths),
		.grip_state_i(st), .drive_enable_i(en), .grip_command_i(1'b0), .release_command_i(rel), .grip_cycle_done_i(done),
		.temperature_i(temp), .param_write_i(wr), .param_read_i(rd), .param_index_i(idx), .param_subindex_i(8'h0),
		.param_wdata_i(wd), .frame_start_i(fs), .cyclic_input_word_o(word), .link_byte_o(lb), .link_byte_valid_o(lv),
		.param_rdata_o(rdata), .param_ack_o(ack), .param_error_o(err), .grip_allowed_o(allow), .store_request_o(store));
	gsw_master_model gsw_master_model_inst (.clk_i(clk), .go_i(go), .link_byte_i(lb), .link_valid_i(lv),
		.frame_start_o(fs), .rx_word_o(rx), .switch_center_o(centers), .switch_width_o(widths));
	// store pulses tallied; ceiling far above the roughly 90 cycles needed
	always @(posedge clk) begin
		cyc = cyc + 1;
		stores = stores + store;
		if (cyc == 4000) begin
			n_errors = n_errors + 1;
			close_out;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// d is write data or expected read data; answer stands one cycle only
	task acc(input w, input [15:0] a, input [15:0] d, input e);
		begin
			wr = w;
			rd = !w;
			idx = a;
			wd = d;
			@(negedge clk);
			wr = 1'b0;
			rd = 1'b0;
			chk({ack, err}, {1'b1, e});
			if (!w && !e)
				chk(rdata, d);
			// idle cycle, so a strobe is never lowered and raised in one step
			@(negedge clk);
		end
	endtask
	task close_out;
		begin
			$display("compares %0d mismatches %0d", cmp_count, n_errors);
			if (n_errors == 0 && cmp_count > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// main sequence
	initial begin
		repeat (5) @(negedge clk);
		reset = 1'b0;
		acc(0, `GSW_IDX_ERROR_TALLY, 16'h0, 0);
		acc(0, `GSW_IDX_HEALTH_SUMMARY, 16'h0, 0);
		acc(0, 16'h0010, 16'h0, 1);
		acc(1, `GSW_IDX_ERROR_TALLY, 16'h5, 1);
		acc(0, `GSW_IDX_COMMAND_TRIGGER, 16'h0, 1);
		$display("register test done");
		jaw = 16'hfe0c;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
		repeat (8) @(negedge clk);
		chk(rx & 32'hfffff8ff, {16'hfe0c, 16'h5000});
		for (i = 0; i < 5; i = i + 1) begin
			st = i;
			repeat (2) @(negedge clk);
			chk(word[4:1], (5'h1 << i) >> 1);
		end
		acc(0, `GSW_IDX_HEALTH_SUMMARY, 16'h4, 0);
		acc(0, `GSW_IDX_ERROR_TALLY, 16'h1, 0);
		st = 3'h3;
		repeat (2) @(negedge clk);
		st = 3'h2;
		repeat (2) @(negedge clk);
		chk(word[11], 1);
		st = 3'h1;
		rel = 1'b1;
		en = 1'b0;
		repeat (2) @(negedge clk);
		chk({word[11], allow, word[0]}, 1);
		rel = 1'b0;
		en = 1'b1;
		$display("state test done");
		for (i = 0; i < 9; i = i + 1) begin
			temp = tv[161 - 18 * i -: 16];
			repeat (2) @(negedge clk);
			chk(word[6:5], tv[145 - 18 * i -: 2]);
		end
		$display("thermal test done");
		snap = stores;
		for (i = 1; i < 8; i = i + 1) begin
			if (i == 5)
				acc(1, `GSW_IDX_COMMAND_TRIGGER, `GSW_CMD_SERVICE_ACK, 0);
			done = 1'b1;
			@(negedge clk);
			done = 1'b0;
			repeat (2) @(negedge clk);
			chk(word[7], i == 4);
		end
		acc(1, `GSW_IDX_COMMAND_TRIGGER, `GSW_CMD_STORE, 0);
		repeat (2) @(negedge clk);
		chk(stores - snap, 1);
		$display("command test done");
		close_out;
	end
endmodule // test_gsw_status_word
